//--- hdl/cfg_protect_pkg.sv
package cfg_protect_pkg;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] REG_CFG1 = 8'h00;
   localparam logic [7:0] REG_CFG2 = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0C;

   // configuration word one field positions
   localparam int MON_BIT = 13;
   localparam int SWOVER_BIT = 12;
   localparam int CLK_OUT_N_BIT = 11;
   localparam int BOR_HI = 10;
   localparam int BOR_LO = 9;
   localparam int EEP_PROT_N_BIT = 8;
   localparam int PROG_PROT_N_BIT = 7;
   localparam int RST_SEL_BIT = 6;
   localparam int PWRT_N_BIT = 5;
   localparam int WDT_HI = 4;
   localparam int WDT_LO = 3;
   localparam int OSC_HI = 2;
   localparam int OSC_LO = 0;

   // configuration word two field positions
   localparam int LOWV_BIT = 13;
   localparam int SHLD_HI = 1;
   localparam int SHLD_LO = 0;

   // control register bits
   localparam int CTRL_SW_BOR_BIT = 0;
   localparam int CTRL_PULLUP_BIT = 1;

   // blank (erased) configuration value
   localparam logic [13:0] CFG_BLANK = 14'h3FFF;

   // oscillator select codes of the three crystal modes
   localparam logic [2:0] OSC_LOWPWR = 3'h0;
   localparam logic [2:0] OSC_STD = 3'h1;
   localparam logic [2:0] OSC_FAST = 3'h2;

   // brown-out mode codes
   localparam logic [1:0] BOR_ON = 2'h3;
   localparam logic [1:0] BOR_AWAKE = 2'h2;
   localparam logic [1:0] BOR_SW = 2'h1;

   // user id window
   localparam logic [15:0] USER_ID_BASE = 16'h8000;
   localparam logic [15:0] USER_ID_LAST = 16'h8003;

   // self-write shield sizes, first unshielded word address per code
   localparam logic [15:0] SHLD_LIMIT_OFF = 16'h0000;
   localparam logic [15:0] SHLD_LIMIT_BOOT = 16'h0200;
   localparam logic [15:0] SHLD_LIMIT_HALF = 16'h2000;
   localparam logic [15:0] SHLD_LIMIT_ALL = 16'h4000;

   // programmer request toward the protected memories
   typedef struct packed {
      logic valid;
      logic write;
      logic eeprom;
      logic [15:0] addr;
      logic [13:0] wdata;
   } ext_req_t;

   // programmer answer
   typedef struct packed {
      logic ack;
      logic blocked;
      logic [13:0] rdata;
      logic prog_wr;
      logic eep_wr;
   } ext_rsp_t;

   // cpu internal request
   typedef struct packed {
      logic valid;
      logic write;
      logic eeprom;
      logic [15:0] addr;
      logic [13:0] wdata;
   } cpu_req_t;

   // cpu internal answer
   typedef struct packed {
      logic ack;
      logic [13:0] rdata;
      logic prog_wr;
      logic eep_wr;
      logic wr_refused;
   } cpu_rsp_t;

   // decoded static controls
   typedef struct packed {
      logic fail_safe_monitor_enable;
      logic clock_switchover_enable;
      logic clock_output_drive;
      logic osc_on_clock_pin;
      logic brownout_active;
      logic powerup_timer_enable;
      logic reset_pin_is_reset;
      logic reset_pin_pullup;
      logic [1:0] watchdog_mode;
   } ctl_t;

   // load phase after reset
   typedef enum logic {
      ST_LOAD = 1'b0,
      ST_RUN = 1'b1
   } phase_t;

endpackage

//--- hdl/access_gate.sv
`timescale 1ns/100ps
`default_nettype none

// one protected memory as seen from the external programmer
module access_gate #(
   parameter int W = 14
) (
   input wire logic req_i,
   input wire logic write_i,
   input wire logic protect_n_i,
   input wire logic [W-1:0] mem_rdata_i,
   output logic grant_wr_o,
   output logic blocked_o,
   output logic [13:0] rdata_o
);

   // protection active when the enable-low bit is cleared
   logic prot;

   always_comb begin
      prot = ~protect_n_i;
      // writes pass only when unprotected
      grant_wr_o = req_i & write_i & ~prot;
      // any access while protected is refused
      blocked_o = req_i & prot;
      rdata_o = 14'h0000;
      // reads of a protected memory return zeros
      if (req_i && !write_i && !prot) begin
         rdata_o[W-1:0] = mem_rdata_i;
      end
   end

endmodule // access_gate

`default_nettype wire

//--- hdl/config_word_code_protection.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [R1] bit 13 set enables fail-safe clock monitor
// [R2] bit 12 set enables clock switchover mode
// [R3] crystal modes ignore clock output enable
// [R4] other modes: enable low drives clock out
// [R5] brown-out field selects on, awake, software, off
// [R6] data protected when bit 8 is zero
// [R7] program protected when bit 7 is zero
// [R8] low-voltage programming ignores pin select; else reset
// [R9] pin select zero gives input, port pull-up
// [R10] brown-out never enables power-up timer
// [R11] unprotecting erase clears whole data eeprom
// [R12] unprotecting program memory erases it all
// [R13] protections independent, cpu not restricted by them
// [R14] protected program: block writes, reads zero
// [R15] protected data: block external reads, writes
// [R16] cpu always reads and writes eeprom
// [R17] cpu reads program; writes follow shield
// [R18] two-bit field sizes self-write shielded block
// [R19] four user id words at 8000h-8003h
// [R20] configuration sampled at reset, then static
module config_word_code_protection (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [13:0] nvm_cfg1_i,
   input wire logic [13:0] nvm_cfg2_i,
   input wire logic sleep_i,
   input wire logic ext_erase_i,
   input wire cfg_protect_pkg::ext_req_t ext_req_i,
   output cfg_protect_pkg::ext_rsp_t ext_rsp_o,
   input wire cfg_protect_pkg::cpu_req_t cpu_req_i,
   output cfg_protect_pkg::cpu_rsp_t cpu_rsp_o,
   input wire logic [13:0] prog_rdata_i,
   input wire logic [7:0] eep_rdata_i,
   output logic prog_erase_all_o,
   output logic eep_erase_all_o,
   output cfg_protect_pkg::ctl_t ctl_o
);

   // whole state of the block
   typedef struct packed {
      cfg_protect_pkg::phase_t phase;
      logic [13:0] cfg1;
      logic [13:0] cfg2;
      logic [3:0][13:0] user_id;
      logic sw_bor;
      logic pullup_bit;
      logic [1:0] sticky;
      logic wb_ack;
      logic [31:0] wb_dat;
      cfg_protect_pkg::ext_rsp_t ext;
      cfg_protect_pkg::cpu_rsp_t cpu;
      logic erase_prog;
      logic erase_eep;
      cfg_protect_pkg::ctl_t ctl;
   } state_t;

   state_t st; // registered state
   state_t next_st; // next state

   // gate outputs for both memories
   logic [1:0] gate_wr;
   logic [1:0] gate_blk;
   logic [1:0][13:0] gate_rd;
   logic [13:0] eep_rd14; // eeprom data widened
   logic ext_take; // programmer request taken this cycle
   logic cpu_take; // cpu request taken this cycle
   logic wb_take; // bus request taken this cycle
   logic id_hit; // cpu address in user id window
   logic [1:0] id_idx; // user id word index
   logic [15:0] shld_limit; // first cpu-writable word

   // true for the three crystal oscillator modes
   function automatic logic is_crystal(input logic [2:0] osc);
      is_crystal = (osc == cfg_protect_pkg::OSC_LOWPWR) || (osc == cfg_protect_pkg::OSC_STD)
         || (osc == cfg_protect_pkg::OSC_FAST);
   endfunction

   // shield size decode of the self-write field
   function automatic logic [15:0] shield_limit(input logic [1:0] code);
      case (code)
         2'h3: shield_limit = cfg_protect_pkg::SHLD_LIMIT_OFF;
         2'h2: shield_limit = cfg_protect_pkg::SHLD_LIMIT_BOOT;
         2'h1: shield_limit = cfg_protect_pkg::SHLD_LIMIT_HALF;
         default: shield_limit = cfg_protect_pkg::SHLD_LIMIT_ALL;
      endcase
   endfunction

   assign eep_rd14 = {6'h00, eep_rdata_i};
   assign ext_take = (st.phase == cfg_protect_pkg::ST_RUN) && ext_req_i.valid && !st.ext.ack;
   assign cpu_take = (st.phase == cfg_protect_pkg::ST_RUN) && cpu_req_i.valid && !st.cpu.ack;
   assign wb_take = wb_cyc_i && wb_stb_i && !st.wb_ack;
   assign id_hit = (cpu_req_i.addr >= cfg_protect_pkg::USER_ID_BASE)
      && (cpu_req_i.addr <= cfg_protect_pkg::USER_ID_LAST);
   assign id_idx = cpu_req_i.addr[1:0];
   assign shld_limit = shield_limit(st.cfg2[cfg_protect_pkg::SHLD_HI:cfg_protect_pkg::SHLD_LO]);

   // program memory gate, external side only
   access_gate #(.W(14)) u_prog_gate (
      .req_i(ext_take && !ext_req_i.eeprom),
      .write_i(ext_req_i.write),
      .protect_n_i(st.cfg1[cfg_protect_pkg::PROG_PROT_N_BIT]), // R7 R14
      .mem_rdata_i(prog_rdata_i),
      .grant_wr_o(gate_wr[0]),
      .blocked_o(gate_blk[0]),
      .rdata_o(gate_rd[0])
   );

   // data eeprom gate, independent of the program gate
   access_gate #(.W(8)) u_eep_gate (
      .req_i(ext_take && ext_req_i.eeprom),
      .write_i(ext_req_i.write),
      .protect_n_i(st.cfg1[cfg_protect_pkg::EEP_PROT_N_BIT]), // R6 R13 R15
      .mem_rdata_i(eep_rd14[7:0]),
      .grant_wr_o(gate_wr[1]),
      .blocked_o(gate_blk[1]),
      .rdata_o(gate_rd[1])
   );

   // next-state logic
   always_comb begin
      next_st = st;
      // pulses last one cycle
      next_st.wb_ack = 1'b0;
      next_st.ext.ack = 1'b0;
      next_st.ext.prog_wr = 1'b0;
      next_st.ext.eep_wr = 1'b0;
      next_st.cpu.ack = 1'b0;
      next_st.cpu.prog_wr = 1'b0;
      next_st.cpu.eep_wr = 1'b0;
      next_st.erase_prog = 1'b0;
      next_st.erase_eep = 1'b0;

      // capture the words once after reset, then hold them
      if (st.phase == cfg_protect_pkg::ST_LOAD) begin
         next_st.cfg1 = nvm_cfg1_i; // R20
         next_st.cfg2 = nvm_cfg2_i; // R20
         next_st.phase = cfg_protect_pkg::ST_RUN;
      end

      // bulk erase lifts protection, so both memories clear entirely
      if (ext_erase_i && st.phase == cfg_protect_pkg::ST_RUN) begin
         next_st.erase_prog = 1'b1; // R12
         next_st.erase_eep = 1'b1; // R11
      end

      // programmer access through the gates
      if (ext_take) begin
         next_st.ext.ack = 1'b1;
         next_st.ext.blocked = |gate_blk;
         next_st.ext.rdata = ext_req_i.eeprom ? gate_rd[1] : gate_rd[0]; // R14 R15
         next_st.ext.prog_wr = gate_wr[0]; // R14
         next_st.ext.eep_wr = gate_wr[1]; // R15
      end

      // cpu access ignores code protection
      if (cpu_take) begin
         next_st.cpu.ack = 1'b1;
         next_st.cpu.wr_refused = 1'b0;
         if (id_hit) begin
            // user id words live here, read and write freely
            next_st.cpu.rdata = st.user_id[id_idx]; // R19
            if (cpu_req_i.write) begin
               next_st.user_id[id_idx] = cpu_req_i.wdata; // R19
            end
         end else if (cpu_req_i.eeprom) begin
            next_st.cpu.rdata = eep_rd14; // R16
            next_st.cpu.eep_wr = cpu_req_i.write; // R16
         end else begin
            next_st.cpu.rdata = prog_rdata_i; // R17
            // only the shielded block refuses self-writes
            if (cpu_req_i.write && cpu_req_i.addr >= shld_limit) begin
               next_st.cpu.prog_wr = 1'b1; // R17 R18
            end else if (cpu_req_i.write) begin
               next_st.cpu.wr_refused = 1'b1; // R18
            end
         end
      end

      // register bus, answer one cycle after the request
      if (wb_take) begin
         next_st.wb_ack = 1'b1;
         next_st.wb_dat = 32'h0000_0000;
         if (wb_adr_i == cfg_protect_pkg::REG_CFG1) begin
            next_st.wb_dat[13:0] = st.cfg1;
         end else if (wb_adr_i == cfg_protect_pkg::REG_CFG2) begin
            next_st.wb_dat[13:0] = st.cfg2;
         end else if (wb_adr_i == cfg_protect_pkg::REG_STATUS) begin
            next_st.wb_dat[1:0] = st.sticky;
            next_st.wb_dat[2] = st.phase;
            next_st.wb_dat[12:3] = st.ctl;
            // write one to clear the sticky blocked flags
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.sticky = st.sticky & ~wb_dat_i[1:0];
            end
         end else if (wb_adr_i == cfg_protect_pkg::REG_CTRL) begin
            next_st.wb_dat[cfg_protect_pkg::CTRL_SW_BOR_BIT] = st.sw_bor;
            next_st.wb_dat[cfg_protect_pkg::CTRL_PULLUP_BIT] = st.pullup_bit;
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.sw_bor = wb_dat_i[cfg_protect_pkg::CTRL_SW_BOR_BIT];
               next_st.pullup_bit = wb_dat_i[cfg_protect_pkg::CTRL_PULLUP_BIT];
            end
         end else begin
            // unmapped: acknowledged, reads zero, writes dropped
            next_st.wb_dat = 32'h0000_0000;
         end
      end

      // refused programmer accesses set the flags; set beats clear
      next_st.sticky = next_st.sticky | (ext_take ? gate_blk : 2'h0);

      // decoded static controls
      next_st.ctl.fail_safe_monitor_enable = st.cfg1[cfg_protect_pkg::MON_BIT]; // R1
      next_st.ctl.clock_switchover_enable = st.cfg1[cfg_protect_pkg::SWOVER_BIT]; // R2
      if (is_crystal(st.cfg1[cfg_protect_pkg::OSC_HI:cfg_protect_pkg::OSC_LO])) begin
         next_st.ctl.osc_on_clock_pin = 1'b1; // R3
         next_st.ctl.clock_output_drive = 1'b0; // R3
      end else begin
         next_st.ctl.osc_on_clock_pin = 1'b0; // R4
         next_st.ctl.clock_output_drive = ~st.cfg1[cfg_protect_pkg::CLK_OUT_N_BIT]; // R4
      end
      case (st.cfg1[cfg_protect_pkg::BOR_HI:cfg_protect_pkg::BOR_LO])
         cfg_protect_pkg::BOR_ON: next_st.ctl.brownout_active = 1'b1; // R5
         cfg_protect_pkg::BOR_AWAKE: next_st.ctl.brownout_active = ~sleep_i; // R5
         cfg_protect_pkg::BOR_SW: next_st.ctl.brownout_active = st.sw_bor; // R5
         default: next_st.ctl.brownout_active = 1'b0; // R5
      endcase
      // power-up timer follows its own bit only
      next_st.ctl.powerup_timer_enable = ~st.cfg1[cfg_protect_pkg::PWRT_N_BIT]; // R10
      next_st.ctl.watchdog_mode = st.cfg1[cfg_protect_pkg::WDT_HI:cfg_protect_pkg::WDT_LO];
      if (st.cfg2[cfg_protect_pkg::LOWV_BIT] || st.cfg1[cfg_protect_pkg::RST_SEL_BIT]) begin
         // select ignored under low-voltage programming
         next_st.ctl.reset_pin_is_reset = 1'b1; // R8
         next_st.ctl.reset_pin_pullup = 1'b1; // R8
      end else begin
         next_st.ctl.reset_pin_is_reset = 1'b0; // R9
         next_st.ctl.reset_pin_pullup = st.pullup_bit; // R9
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.cfg1 <= cfg_protect_pkg::CFG_BLANK;
         st.cfg2 <= cfg_protect_pkg::CFG_BLANK;
         st.phase <= cfg_protect_pkg::ST_LOAD;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign wb_ack_o = st.wb_ack;
   assign wb_dat_o = st.wb_dat;
   assign ext_rsp_o = st.ext;
   assign cpu_rsp_o = st.cpu;
   assign prog_erase_all_o = st.erase_prog;
   assign eep_erase_all_o = st.erase_eep;
   assign ctl_o = st.ctl;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // monitor enable follows bit 13 one cycle into run
   property p_fscm;
      (st.phase == cfg_protect_pkg::ST_RUN) |=> (ctl_o.fail_safe_monitor_enable == st.cfg1[13]);
   endproperty
   a_fscm: assert property (p_fscm) else $error("monitor enable mismatch"); // R1

   // switchover follows bit 12
   property p_swover;
      (st.phase == cfg_protect_pkg::ST_RUN) |=> (ctl_o.clock_switchover_enable == st.cfg1[12]);
   endproperty
   a_swover: assert property (p_swover) else $error("switchover mismatch"); // R2

   // crystal modes never drive the clock output
   property p_xtal;
      (st.phase == cfg_protect_pkg::ST_RUN && st.cfg1[2:0] <= 3'h2)
         |=> (!ctl_o.clock_output_drive && ctl_o.osc_on_clock_pin);
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal mode drives clock out"); // R3

   // other modes drive the clock out when the bit is low
   property p_clock_output_pin;
      (st.phase == cfg_protect_pkg::ST_RUN && st.cfg1[2:0] > 3'h2)
         |=> (ctl_o.clock_output_drive == !$past(st.cfg1[11]));
   endproperty
   a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock out enable wrong"); // R4

   // awake-only brown-out follows the sleep state
   property p_bor;
      (st.phase == cfg_protect_pkg::ST_RUN && st.cfg1[10:9] == 2'h2)
         |=> (ctl_o.brownout_active == !$past(sleep_i));
   endproperty
   a_bor: assert property (p_bor) else $error("awake-only brown-out wrong"); // R5

   // protected program read answers zero and writes nothing
   property p_prog_prot;
      (ext_take && !ext_req_i.eeprom && !st.cfg1[7])
         |=> (ext_rsp_o.ack && ext_rsp_o.rdata == 14'h0000 && !ext_rsp_o.prog_wr && ext_rsp_o.blocked);
   endproperty
   a_prog_prot: assert property (p_prog_prot) else $error("protected program access leaked"); // R14

   // protected eeprom refuses writes
   property p_eep_prot;
      (ext_take && ext_req_i.eeprom && !st.cfg1[8]) |=> (!ext_rsp_o.eep_wr && ext_rsp_o.blocked);
   endproperty
   a_eep_prot: assert property (p_eep_prot) else $error("protected eeprom access leaked"); // R15

   // cpu program reads pass whatever the protection
   property p_cpu_read;
      (cpu_take && !id_hit && !cpu_req_i.eeprom)
         |=> (cpu_rsp_o.ack && cpu_rsp_o.rdata == $past(prog_rdata_i));
   endproperty
   a_cpu_read: assert property (p_cpu_read) else $error("cpu program read altered"); // R17

   // shielded addresses never see a cpu write
   property p_shield;
      (cpu_take && cpu_req_i.write && !id_hit && !cpu_req_i.eeprom && cpu_req_i.addr < shld_limit)
         |=> (!cpu_rsp_o.prog_wr && cpu_rsp_o.wr_refused);
   endproperty
   a_shield: assert property (p_shield) else $error("shielded self-write passed"); // R18

   // configuration stays fixed once running
   property p_static;
      (st.phase == cfg_protect_pkg::ST_RUN) |=> ($stable(st.cfg1) && $stable(st.cfg2));
   endproperty
   a_static: assert property (p_static) else $error("configuration changed while running"); // R20

endmodule // config_word_code_protection

`default_nettype wire

//--- bench/ext_programmer_model.sv
`timescale 1ns/100ps
`default_nettype none

// behavioural external programmer on the protected-memory access port
module ext_programmer_model (
   input wire logic clk_i, // system clock
   output cfg_protect_pkg::ext_req_t ext_req_o, // request toward the block
   input wire cfg_protect_pkg::ext_rsp_t ext_rsp_i // answer from the block
);

   // no request pending at time zero
   initial begin
      ext_req_o = '0;
   end

   // one access: request held until ack is sampled, then released with scrambled idle lines
   task automatic access(input logic wr, input logic eep, input logic [15:0] adr, input logic [13:0] wd,
                         output cfg_protect_pkg::ext_rsp_t rsp, output logic done);
      int n;
      n = 0;
      @(posedge clk_i);
      ext_req_o <= '{valid: 1'h1, write: wr, eeprom: eep, addr: adr, wdata: wd};
      // bounded wait for the answer
      do begin
         @(posedge clk_i);
         n++;
      end while (ext_rsp_i.ack !== 1'h1 && n < 50);
      rsp = ext_rsp_i;
      done = (ext_rsp_i.ack === 1'h1);
      // released lines must not keep the last value
      ext_req_o <= '{valid: 1'h0, write: ~wr, eeprom: ~eep, addr: ~adr, wdata: ~wd};
   endtask

endmodule // ext_programmer_model

`default_nettype wire

//--- bench/config_word_code_protection_test.sv
`timescale 1ns/100ps
`default_nettype none

// self-checking bench for configuration decode and code protection
module config_word_code_protection_test;
   logic clk_i; // system clock
   logic rst_i; // synchronous reset
   logic wb_cyc, wb_stb, wb_we, wb_ack; // wishbone handshake
   logic [7:0] wb_adr; // register byte address
   logic [3:0] wb_sel; // byte selects
   logic [31:0] wb_wdat, wb_rdat, q; // write data, read data, last read
   logic [13:0] nvm1, nvm2; // stored configuration words
   logic sleep, erase; // power state and bulk erase request
   cfg_protect_pkg::ext_req_t ext_req; // programmer request
   cfg_protect_pkg::ext_rsp_t ext_rsp; // programmer answer
   cfg_protect_pkg::cpu_req_t cpu_req; // cpu request
   cfg_protect_pkg::cpu_rsp_t cpu_rsp; // cpu answer
   logic [15:0] mem_adr; // address seen by the memories
   logic [13:0] prog_rdata; // program memory data
   logic [7:0] eep_rdata; // eeprom data
   logic prog_erase, eep_erase; // erase pulses
   cfg_protect_pkg::ctl_t ctl; // decoded controls
   int n_mismatch, n_compared; // counters

   // memory contents are a fixed function of the address
   function automatic logic [13:0] pword(input logic [15:0] a);
      return a[13:0] ^ 14'h1555;
   endfunction
   function automatic logic [7:0] eword(input logic [15:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction
   // memories answer at whichever address is being requested
   assign mem_adr = ext_req.valid ? ext_req.addr : cpu_req.addr;
   assign prog_rdata = pword(mem_adr);
   assign eep_rdata = eword(mem_adr);

   // device under test
   config_word_code_protection i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .nvm_cfg1_i(nvm1), .nvm_cfg2_i(nvm2), .sleep_i(sleep), .ext_erase_i(erase),
      .ext_req_i(ext_req), .ext_rsp_o(ext_rsp), .cpu_req_i(cpu_req), .cpu_rsp_o(cpu_rsp),
      .prog_rdata_i(prog_rdata), .eep_rdata_i(eep_rdata), .prog_erase_all_o(prog_erase),
      .eep_erase_all_o(eep_erase), .ctl_o(ctl)
   );

   // far-side programmer
   ext_programmer_model i_prog (
      .clk_i(clk_i), .ext_req_o(ext_req), .ext_rsp_i(ext_rsp)
   );

   // clock generator
   initial begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic summarize;
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // a wait that ran out ends the run
   task automatic bound(input logic ok);
      if (ok !== 1'h1) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: handshake timed out", $time);
         summarize();
      end
   endtask

   // classic wishbone single cycle; read data lands in q
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'h1 && n < 50);
      bound(wb_ack);
      q = wb_rdat;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
   endtask

   // programmer access; expected is {rdata, blocked, prog_wr, eep_wr}, rdata ignored on writes
   task automatic ext(input logic wr, input logic eep, input logic [15:0] a, input logic [16:0] exp,
                      input string what);
      cfg_protect_pkg::ext_rsp_t r;
      logic ok;
      i_prog.access(wr, eep, a, 14'h2AAA ^ a[13:0], r, ok);
      bound(ok);
      chk({15'h0, wr ? 14'h0 : r.rdata, r.blocked, r.prog_wr, r.eep_wr}, {15'h0, exp}, what);
   endtask

   // cpu access; expected is {rdata, prog_wr, eep_wr, wr_refused}, rdata ignored on writes
   task automatic cpu(input logic wr, input logic eep, input logic [15:0] a, input logic [16:0] exp,
                      input string what);
      int n;
      n = 0;
      @(posedge clk_i);
      cpu_req <= '{valid: 1'h1, write: wr, eeprom: eep, addr: a, wdata: 14'h0F0F};
      do begin
         @(posedge clk_i);
         n++;
      end while (cpu_rsp.ack !== 1'h1 && n < 50);
      bound(cpu_rsp.ack);
      chk({15'h0, wr ? 14'h0 : cpu_rsp.rdata, cpu_rsp.prog_wr, cpu_rsp.eep_wr, cpu_rsp.wr_refused},
          {15'h0, exp}, what);
      cpu_req <= '{valid: 1'h0, write: ~wr, eeprom: ~eep, addr: ~a, wdata: 14'h30F0};
   endtask

   // reset for three cycles with new stored words, then let the load phase finish
   task automatic boot(input logic [13:0] c1, input logic [13:0] c2);
      @(posedge clk_i);
      rst_i <= 1'h1;
      nvm1 <= c1;
      nvm2 <= c2;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (4) @(posedge clk_i);
   endtask

   // main sequence
   initial begin
      rst_i = 1'h1;
      {wb_cyc, wb_stb, wb_we, sleep, erase} = 5'h0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_wdat = 32'h0;
      cpu_req = '0;
      nvm1 = 14'h0;
      nvm2 = 14'h0;
      n_mismatch = 0;
      n_compared = 0;
      // program protected, eeprom open, non-crystal oscillator, boot block shielded
      boot(14'h2774, 14'h0002);
      nvm1 <= 14'h0000;
      nvm2 <= 14'h3FFF;
      wb(1'h0, cfg_protect_pkg::REG_CFG1, 32'h0);
      chk(q, 32'h2774, "first word");
      wb(1'h1, cfg_protect_pkg::REG_CFG1, 32'hFFFF);
      wb(1'h0, cfg_protect_pkg::REG_CFG1, 32'h0);
      chk(q, 32'h2774, "first word read only");
      wb(1'h0, cfg_protect_pkg::REG_CFG2, 32'h0);
      chk(q, 32'h0002, "second word");
      wb(1'h0, 8'h10, 32'h0);
      chk(q, 32'h0, "unmapped read");
      wb(1'h0, cfg_protect_pkg::REG_CTRL, 32'h0);
      chk(q, 32'h0, "control reset value");
      chk(32'(ctl), 32'h2AE, "decode set a");
      sleep <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk(32'(ctl), 32'h2AE, "brown-out on in sleep");
      sleep <= 1'h0;
      ext(1'h0, 1'h0, 16'h0123, {14'h0, 3'h4}, "protected program read");
      ext(1'h1, 1'h0, 16'h0123, {14'h0, 3'h4}, "protected program write");
      ext(1'h0, 1'h1, 16'h0045, {6'h0, eword(16'h0045), 3'h0}, "open eeprom read");
      ext(1'h1, 1'h1, 16'h0045, {14'h0, 3'h1}, "open eeprom write");
      wb(1'h0, cfg_protect_pkg::REG_STATUS, 32'h0);
      chk(q, {19'h0, 10'h2AE, 3'h5}, "refusal recorded");
      wb(1'h1, cfg_protect_pkg::REG_STATUS, 32'h3);
      wb(1'h0, cfg_protect_pkg::REG_STATUS, 32'h0);
      chk(q, {19'h0, 10'h2AE, 3'h4}, "refusal cleared");
      cpu(1'h0, 1'h0, 16'h0123, {pword(16'h0123), 3'h0}, "cpu program read");
      cpu(1'h1, 1'h0, 16'h01FF, {14'h0, 3'h1}, "shielded self write");
      cpu(1'h1, 1'h0, 16'h0200, {14'h0, 3'h4}, "open self write");
      cpu(1'h1, 1'h0, 16'h8003, {14'h0, 3'h0}, "id word write");
      cpu(1'h0, 1'h0, 16'h8003, {14'h0F0F, 3'h0}, "id word read");
      cpu(1'h1, 1'h1, 16'h0010, {14'h0, 3'h2}, "cpu eeprom write");
      // bulk erase clears both memories with one pulse each
      @(posedge clk_i);
      erase <= 1'h1;
      @(posedge clk_i);
      erase <= 1'h0;
      @(posedge clk_i);
      chk({30'h0, prog_erase, eep_erase}, 32'h3, "erase pulses");
      @(posedge clk_i);
      chk({30'h0, prog_erase, eep_erase}, 32'h0, "erase pulses end");
      // eeprom protected, program open, crystal oscillator, no shield
      boot(14'h1289, 14'h0003);
      chk(32'(ctl), 32'h151, "decode set b");
      wb(1'h1, cfg_protect_pkg::REG_CTRL, 32'h3);
      repeat (3) @(posedge clk_i);
      chk(32'(ctl), 32'h175, "software brown-out and pull-up");
      ext(1'h0, 1'h0, 16'h0777, {pword(16'h0777), 3'h0}, "open program read");
      ext(1'h1, 1'h0, 16'h0777, {14'h0, 3'h2}, "open program write");
      ext(1'h0, 1'h1, 16'h0045, {14'h0, 3'h4}, "protected eeprom read");
      ext(1'h1, 1'h1, 16'h0045, {14'h0, 3'h4}, "protected eeprom write");
      cpu(1'h0, 1'h1, 16'h0045, {6'h0, eword(16'h0045), 3'h0}, "cpu eeprom read");
      cpu(1'h1, 1'h0, 16'h0000, {14'h0, 3'h4}, "unshielded self write");
      // low-voltage programming, awake-only brown-out, clock output off
      boot(14'h3DBF, 14'h2003);
      chk(32'(ctl), 32'h32F, "decode set c");
      sleep <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk(32'(ctl), 32'h30F, "brown-out off in sleep");
      // brown-out field cleared, device awake again
      sleep <= 1'h0;
      boot(14'h39BF, 14'h2003);
      chk(32'(ctl), 32'h30F, "brown-out disabled");
      summarize();
   end

endmodule // config_word_code_protection_test

`default_nettype wire
